// ---- include/nvm_ctrl_pkg.sv ----
// constants and types shared by the nonvolatile memory control block
package nvm_ctrl_pkg;

  // ***************************************************
  // register location and fields
  // ***************************************************
  localparam logic [7:0] MEM_CTRL_ADDR = 8'h96; // nv_memory_control
  localparam logic [7:0] MEM_CTRL_RESET = 8'h00;
  localparam int APP_PROG_BIT = 7;
  localparam int AUTO_ERASE_BIT = 6;
  localparam int PAGE_LOAD_BIT = 5;
  localparam int NV_WEN_BIT = 4;
  localparam int DFLASH_EN_BIT = 3;
  localparam int ABORT_BIT = 2;
  localparam int UNUSED_BIT = 1;
  localparam int WINHIBIT_BIT = 0;

  // ***************************************************
  // page geometry
  // ***************************************************
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_IDX_W = 6;
  localparam int ADDR_W = 16;
  localparam int PAGE_NUM_W = ADDR_W - PAGE_IDX_W;

  // ***************************************************
  // address space selected for a move instruction
  // ***************************************************
  typedef enum logic [1:0] {
    SPACE_EXTRA_RAM,
    SPACE_FLASH_DATA,
    SPACE_CODE,
    SPACE_SIGNATURE
  } space_t;

endpackage

// ---- include/nv_page_if.sv ----
// carrier between write sequencer and temporary page buffer
`timescale 1ns/1ps
interface nv_page_if #(parameter int IDX_W = 6);
  logic loadEn;
  logic [IDX_W-1:0] loadIdx;
  logic [7:0] loadData;
  logic clearAll;
  logic [IDX_W-1:0] rdIdx;
  logic [7:0] rdData;
  logic rdLoaded;
  logic anyLoaded;

  modport ctrl (
    output loadEn, loadIdx, loadData, clearAll, rdIdx,
    input rdData, rdLoaded, anyLoaded
  );
  modport store (
    input loadEn, loadIdx, loadData, clearAll, rdIdx,
    output rdData, rdLoaded, anyLoaded
  );
endinterface

// ---- rtl/nv_page_buffer.sv ----
// temporary page buffer with per-byte loaded marks
`timescale 1ns/1ps
module nv_page_buffer #(
  parameter int DEPTH = 64,
  parameter int IDX_W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sequencer side
  nv_page_if.store pg
);
  import nvm_ctrl_pkg::*;

  logic [7:0] mem [DEPTH];
  logic [DEPTH-1:0] loaded_reg;

  // byte storage, no reset needed
  always_ff @(posedge clk) begin
    if (pg.loadEn) begin
      mem[pg.loadIdx] <= pg.loadData;
    end
  end

  // loaded marks, cleared after every write operation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loaded_reg <= '0;
    end else if (pg.clearAll) begin
      loaded_reg <= '0;
    end else if (pg.loadEn) begin
      loaded_reg[pg.loadIdx] <= 1'b1;
    end
  end

  // read side
  assign pg.rdData = mem[pg.rdIdx];
  assign pg.rdLoaded = loaded_reg[pg.rdIdx];
  assign pg.anyLoaded = |loaded_reg;
endmodule // nv_page_buffer

// ---- rtl/flash_write_and_map_control.sv ----
// nonvolatile write sequencing and move-instruction space routing
// Function
// R01: no write start while brownout reports low
// R02: brownout during write sets abort flag
// R03: flash data reads always complete
// R04: abort flag held until software clears
// R05: inhibit flag zero below programming voltage
// R06: app bit redirects pointer moves to code
// R07: disabled fuse forces app bit zero
// R08: auto-erase erases page before writing
// R09: page-load accepts bytes without starting write
// R10: write-enable bit gates all programming
// R11: data-flash bit enables flash data space
// R12: control register resets bits 7..2 zero
// R13: code writes use same sequencing
// R14: cpu held idle during programming
// R15: routing map for external and code moves
// R16: 64-byte buffer reset after each write
// R17: final write starts sequence, selects page
// R18: programming only clears bits
// R19: interrupts deferred during write
// R20: unused bit 1 ignores writes
`timescale 1ns/1ps
module flash_write_and_map_control #(
  parameter int PAGE_DEPTH = nvm_ctrl_pkg::PAGE_BYTES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // special function register access
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // move instruction request from the core
  input wire logic movReq,
  input wire logic movWrite,
  input wire logic movIsCode,
  input wire logic [nvm_ctrl_pkg::ADDR_W-1:0] movAddr,
  input wire logic [7:0] movWdata,
  input wire logic signatureSelect,
  output logic movAck,
  output nvm_ctrl_pkg::space_t movSpace,
  output logic ramWriteEn,
  // core control
  output logic cpuHold,
  output logic intDefer,
  // supply and fuse status
  input wire logic brownoutLow,
  input wire logic appFuseEn,
  // flash array port
  output logic flashErase,
  output logic flashProg,
  output logic flashRdEn,
  output nvm_ctrl_pkg::space_t flashSpace,
  output logic [nvm_ctrl_pkg::ADDR_W-1:0] flashAddr,
  output logic [7:0] flashWdata,
  input wire logic [7:0] flashRdata,
  input wire logic flashDone
);
  import nvm_ctrl_pkg::*;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_ERASE, SEQ_SCAN, SEQ_READ, SEQ_MERGE, SEQ_PROG, SEQ_END
  } seq_t;

  // ***************************************************
  // control register
  // ***************************************************
  logic appProg_reg, autoErase_reg, pageLoad_reg, nvWen_reg, dflashEn_reg;
  logic abort_reg;
  logic ctrlWrite, abortSet, appProg;
  seq_t state_reg;
  logic [PAGE_IDX_W-1:0] idx_reg;
  logic [PAGE_NUM_W-1:0] page_reg;
  logic [7:0] merged;

  nv_page_if #(.IDX_W(PAGE_IDX_W)) pg ();

  assign ctrlWrite = sfrWrite && (sfrAddr == MEM_CTRL_ADDR);
  assign appProg = appProg_reg && appFuseEn; // [R07]

  // writable control bits, all zero after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      appProg_reg <= MEM_CTRL_RESET[APP_PROG_BIT]; // [R12]
      autoErase_reg <= MEM_CTRL_RESET[AUTO_ERASE_BIT];
      pageLoad_reg <= MEM_CTRL_RESET[PAGE_LOAD_BIT];
      nvWen_reg <= MEM_CTRL_RESET[NV_WEN_BIT];
      dflashEn_reg <= MEM_CTRL_RESET[DFLASH_EN_BIT];
    end else if (ctrlWrite) begin
      appProg_reg <= sfrWdata[APP_PROG_BIT] && appFuseEn; // [R07]
      autoErase_reg <= sfrWdata[AUTO_ERASE_BIT];
      pageLoad_reg <= sfrWdata[PAGE_LOAD_BIT];
      nvWen_reg <= sfrWdata[NV_WEN_BIT];
      dflashEn_reg <= sfrWdata[DFLASH_EN_BIT];
    end else if (!appFuseEn) begin
      appProg_reg <= 1'b0; // [R07]
    end
  end

  // abort flag: hardware sets, software writes zero, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abort_reg <= MEM_CTRL_RESET[ABORT_BIT]; // [R12]
    end else if (abortSet) begin
      abort_reg <= 1'b1; // [R02] [R04]
    end else if (ctrlWrite && !sfrWdata[ABORT_BIT]) begin
      abort_reg <= 1'b0; // [R04]
    end
  end

  // read back; bit 1 has no storage and reads zero
  always_comb begin
    sfrRdata = '0;
    if (sfrAddr == MEM_CTRL_ADDR) begin
      sfrRdata[APP_PROG_BIT] = appProg;
      sfrRdata[AUTO_ERASE_BIT] = autoErase_reg;
      sfrRdata[PAGE_LOAD_BIT] = pageLoad_reg;
      sfrRdata[NV_WEN_BIT] = nvWen_reg;
      sfrRdata[DFLASH_EN_BIT] = dflashEn_reg;
      sfrRdata[ABORT_BIT] = abort_reg;
      sfrRdata[UNUSED_BIT] = 1'b0; // [R20]
      sfrRdata[WINHIBIT_BIT] = !brownoutLow; // [R05]
    end
  end

  // ***************************************************
  // space routing
  // ***************************************************
  function automatic space_t route(input logic isCode, input logic app,
                                   input logic sig, input logic dflash);
    if (isCode || app) begin
      route = sig ? SPACE_SIGNATURE : SPACE_CODE; // [R06] [R15]
    end else begin
      route = dflash ? SPACE_FLASH_DATA : SPACE_EXTRA_RAM; // [R11] [R15]
    end
  endfunction

  logic nvTarget, nvWrite, startSeq, loadByte, seqIdle;

  assign movSpace = route(movIsCode, appProg, signatureSelect, dflashEn_reg);
  assign seqIdle = (state_reg == SEQ_IDLE);
  assign nvTarget = (movSpace != SPACE_EXTRA_RAM);
  assign nvWrite = movReq && movWrite && !movIsCode && nvTarget && seqIdle
                   && nvWen_reg; // [R10]
  assign loadByte = nvWrite && (pageLoad_reg || !brownoutLow); // [R09]
  assign startSeq = nvWrite && !pageLoad_reg && !brownoutLow; // [R01] [R17]
  assign ramWriteEn = movReq && movWrite && !movIsCode
                      && movSpace == SPACE_EXTRA_RAM && seqIdle;
  // reads answer at once in any supply state; writes wait while busy
  assign movAck = movReq && (!movWrite || seqIdle); // [R03]
  assign cpuHold = !seqIdle; // [R14]
  assign intDefer = !seqIdle; // [R19]

  // buffer load from the core, clear at end of each operation
  assign pg.loadEn = loadByte;
  assign pg.loadIdx = movAddr[PAGE_IDX_W-1:0];
  assign pg.loadData = movWdata;
  assign pg.clearAll = (state_reg == SEQ_END)
                       || (nvWrite && !pageLoad_reg && brownoutLow); // [R16]
  assign pg.rdIdx = idx_reg;

  nv_page_buffer #(.DEPTH(PAGE_DEPTH), .IDX_W(PAGE_IDX_W)) u_buf (
    .clk(clk),
    .rst(rst),
    .pg(pg)
  );

  // ***************************************************
  // write sequencer
  // ***************************************************
  assign merged = flashRdata & pg.rdData; // [R18]
  assign abortSet = !seqIdle && state_reg != SEQ_END && brownoutLow;

  // sequence state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SEQ_IDLE;
      idx_reg <= '0;
      page_reg <= '0;
      flashSpace <= SPACE_EXTRA_RAM;
    end else if (abortSet) begin
      state_reg <= SEQ_END; // [R02]
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          idx_reg <= '0;
          if (startSeq) begin
            page_reg <= movAddr[ADDR_W-1:PAGE_IDX_W]; // [R17]
            flashSpace <= movSpace; // [R13]
            state_reg <= autoErase_reg ? SEQ_ERASE : SEQ_SCAN; // [R08]
          end
        end
        SEQ_ERASE: begin
          if (flashDone) begin
            state_reg <= SEQ_SCAN; // [R08]
          end
        end
        SEQ_SCAN: begin
          if (pg.rdLoaded) begin
            state_reg <= SEQ_READ;
          end else if (idx_reg == PAGE_IDX_W'(PAGE_DEPTH - 1)) begin
            state_reg <= SEQ_END;
          end else begin
            idx_reg <= idx_reg + 1'b1;
          end
        end
        SEQ_READ: begin
          state_reg <= SEQ_MERGE;
        end
        SEQ_MERGE: begin
          state_reg <= SEQ_PROG;
        end
        SEQ_PROG: begin
          if (flashDone) begin
            if (idx_reg == PAGE_IDX_W'(PAGE_DEPTH - 1)) begin
              state_reg <= SEQ_END;
            end else begin
              idx_reg <= idx_reg + 1'b1;
              state_reg <= SEQ_SCAN;
            end
          end
        end
        SEQ_END: begin
          state_reg <= SEQ_IDLE; // [R16]
        end
        default: begin
          state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // flash array strobes and data, all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flashErase <= 1'b0;
      flashProg <= 1'b0;
      flashRdEn <= 1'b0;
      flashAddr <= '0;
      flashWdata <= '0;
    end else begin
      flashErase <= seqIdle && startSeq && autoErase_reg; // [R08]
      flashRdEn <= state_reg == SEQ_SCAN && pg.rdLoaded && !abortSet;
      flashProg <= state_reg == SEQ_MERGE && !abortSet; // [R10]
      if (seqIdle && startSeq) begin
        flashAddr <= {movAddr[ADDR_W-1:PAGE_IDX_W], {PAGE_IDX_W{1'b0}}};
      end else if (state_reg == SEQ_SCAN) begin
        flashAddr <= {page_reg, idx_reg};
      end
      if (state_reg == SEQ_MERGE) begin
        flashWdata <= merged; // [R18]
      end
    end
  end
endmodule // flash_write_and_map_control

// ---- test/nvm_ctrl_monitor.sv ----
// assertion checker for the nonvolatile write and map control block
`timescale 1ns/1ps
module nvm_ctrl_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register and move side
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  input wire logic movReq,
  input wire logic movWrite,
  input wire logic movIsCode,
  input wire logic signatureSelect,
  input wire logic movAck,
  input wire nvm_ctrl_pkg::space_t movSpace,
  input wire logic ramWriteEn,
  // core, supply and array side
  input wire logic cpuHold,
  input wire logic intDefer,
  input wire logic brownoutLow,
  input wire logic appFuseEn,
  input wire logic flashErase
);
  import nvm_ctrl_pkg::*;
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // register selected and expected target space
  logic regSel;
  logic [1:0] expSpace;
  assign regSel = sfrAddr == MEM_CTRL_ADDR;
  assign expSpace = (movIsCode || sfrRdata[7]) ? {1'b1, signatureSelect}
                                               : {1'b0, sfrRdata[3]};
  property p_start_refused;
    movAck && movWrite && !movIsCode && brownoutLow && !cpuHold |=> !cpuHold;
  endproperty
  a_start_refused: assert property (p_start_refused)
    else $error("write started during brownout");
  property p_abort_set;
    cpuHold && brownoutLow ##1 cpuHold && !sfrWrite ##1 regSel
      |-> sfrRdata[ABORT_BIT];
  endproperty
  a_abort_set: assert property (p_abort_set)
    else $error("abort flag not set");
  property p_read_ok;
    movReq && !movWrite && !cpuHold |-> movAck;
  endproperty
  a_read_ok: assert property (p_read_ok)
    else $error("read move not accepted");
  property p_abort_hold;
    regSel && $past(regSel) && $past(sfrRdata[ABORT_BIT])
      && !($past(sfrWrite) && !$past(sfrWdata[ABORT_BIT]))
      |-> sfrRdata[ABORT_BIT];
  endproperty
  a_abort_hold: assert property (p_abort_hold)
    else $error("abort flag lost");
  property p_inhibit;
    regSel && $stable(brownoutLow) && !$past(rst)
      |-> sfrRdata[WINHIBIT_BIT] == !brownoutLow;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit flag wrong");
  property p_route;
    regSel |-> movSpace == expSpace;
  endproperty
  a_route: assert property (p_route)
    else $error("move routed to wrong space");
  property p_fuse_off;
    regSel && !appFuseEn |-> !sfrRdata[APP_PROG_BIT];
  endproperty
  a_fuse_off: assert property (p_fuse_off)
    else $error("app bit set with fuse off");
  property p_wen_gate;
    movAck && movWrite && !movIsCode && regSel && !sfrRdata[NV_WEN_BIT]
      && !cpuHold |=> !cpuHold;
  endproperty
  a_wen_gate: assert property (p_wen_gate)
    else $error("write without write enable");
  property p_erase_first;
    $rose(cpuHold) && $past(regSel) && $past(sfrRdata[AUTO_ERASE_BIT])
      |-> ##[0:2] flashErase;
  endproperty
  a_erase_first: assert property (p_erase_first)
    else $error("no erase at sequence start");
  property p_defer;
    cpuHold |-> intDefer;
  endproperty
  a_defer: assert property (p_defer)
    else $error("interrupts not deferred");
  property p_ram_write;
    ramWriteEn |-> movAck && movWrite && movSpace == SPACE_EXTRA_RAM;
  endproperty
  a_ram_write: assert property (p_ram_write)
    else $error("extra ram written outside its space");
endmodule // nvm_ctrl_monitor

// ---- test/flash_array_model.sv ----
// behavioural flash array answering erase, program and read strobes
`timescale 1ns/1ps
module flash_array_model (
  // clock and latency choice
  input wire logic clk,
  input wire logic slowDone,
  // array port
  input wire logic flashErase,
  input wire logic flashProg,
  input wire logic flashRdEn,
  input wire nvm_ctrl_pkg::space_t flashSpace,
  input wire logic [15:0] flashAddr,
  input wire logic [7:0] flashWdata,
  output logic [7:0] flashRdata,
  output logic flashDone
);
  import nvm_ctrl_pkg::*;
  logic [7:0] mem [0:4095];
  logic [11:0] idx;
  int busyCnt = 0;
  assign idx = {flashSpace, flashAddr[9:0]};
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    flashRdata = 8'h5a;
    flashDone = 1'b0;
  end
  // array update; stale read data flips every cycle
  always @(posedge clk) begin
    flashDone <= 1'b0;
    flashRdata <= flashRdEn ? mem[idx] : ~flashRdata;
    if (flashErase)
      for (int i = 0; i < 64; i++) mem[{idx[11:6], i[5:0]}] = 8'hff;
    if (flashProg)
      mem[idx] = mem[idx] & flashWdata;
    if (flashErase || flashProg)
      busyCnt = slowDone ? 30 : 2;
    else if (busyCnt > 0) begin
      busyCnt--;
      flashDone <= busyCnt == 0;
    end
  end
endmodule // flash_array_model

// ---- test/tb_flash_write_and_map_control.sv ----
// self-checking bench for the write and map control block
`timescale 1ns/1ps
module tb_flash_write_and_map_control;
  import nvm_ctrl_pkg::*;
  // ****************
  // signals and models
  // ****************
  logic clk = 0, rst = 1, sfrWrite = 0, movReq = 0, movWrite = 0;
  logic movIsCode = 0, signatureSelect = 0, brownoutLow = 0;
  logic appFuseEn = 0, slowDone = 0;
  logic [7:0] sfrAddr = MEM_CTRL_ADDR, sfrWdata = 0, movWdata = 0;
  logic [15:0] movAddr = 0, flashAddr;
  logic [7:0] sfrRdata, flashWdata, flashRdata, v;
  logic movAck, ramWriteEn, cpuHold, intDefer, flashErase, flashProg;
  logic flashRdEn, flashDone;
  logic ramSeen = 0;
  space_t movSpace, flashSpace;
  int error_cnt = 0, samples_checked = 0, seed = 35012, cycles = 0;
  logic [7:0] d [0:4];
  flash_write_and_map_control u_dut (.clk, .rst, .sfrAddr, .sfrWrite,
    .sfrWdata, .sfrRdata, .movReq, .movWrite, .movIsCode, .movAddr,
    .movWdata, .signatureSelect, .movAck, .movSpace, .ramWriteEn, .cpuHold,
    .intDefer, .brownoutLow, .appFuseEn, .flashErase, .flashProg,
    .flashRdEn, .flashSpace, .flashAddr, .flashWdata, .flashRdata,
    .flashDone);
  flash_array_model u_flash (.clk, .slowDone, .flashErase, .flashProg,
    .flashRdEn, .flashSpace, .flashAddr, .flashWdata, .flashRdata,
    .flashDone);
  initial begin
    forever #2 clk = ~clk;
  end
  // cycle ceiling against hangs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] val);
    sfrWrite = 1;
    sfrWdata = val;
    tick();
    sfrWrite = 0;
    // one idle edge so back-to-back writes show a low strobe
    tick();
  endtask
  // move request held until accepted at an edge
  task automatic mov(input logic w, input logic [15:0] a, input logic [7:0] b);
    logic ok;
    ok = 0;
    movReq = 1;
    movWrite = w;
    movAddr = a;
    movWdata = b;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(negedge clk) begin
        ok = movAck === 1'b1;
        ramSeen = ramWriteEn;
      end
      tick();
    end
    movReq = 0;
    chk(ok, 1);
    // one idle edge so back-to-back moves show a low request
    tick();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && cpuHold !== 1'b0; i++) tick();
  endtask
  function automatic logic [7:0] exp_space(input logic c, ap, sg, df);
    return (c || ap) ? 8'h02 + sg : {7'h0, df};
  endfunction
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    chk(sfrRdata & 8'hfc, 8'h00);
    chk(sfrRdata[0], 1);
    sfrAddr = 8'h95;
    @(negedge clk) chk(sfrRdata, 8'h00);
    tick();
    sfrAddr = MEM_CTRL_ADDR;
    reg_wr(8'h80);
    chk(sfrRdata[7], 0);
    appFuseEn = 1;
    for (int i = 0; i < 16; i++) begin
      reg_wr({i[3], 3'h0, i[2], 3'h0});
      signatureSelect = i[1];
      movIsCode = i[0];
      @(negedge clk) chk(movSpace, exp_space(i[0], i[3], i[1], i[2]));
      tick();
    end
    movIsCode = 0;
    signatureSelect = 0;
    brownoutLow = 1;
    reg_wr(8'h18);
    chk(sfrRdata[0], 0);
    mov(0, 16'h0240, 8'h00);
    mov(1, 16'h0240, 8'h00);
    chk(cpuHold, 0);
    brownoutLow = 0;
    reg_wr(8'h08);
    mov(1, 16'h0240, 8'h00);
    chk(cpuHold, 0);
    chk(u_flash.mem[12'h640], 8'hff);
    // extra ram write: strobe only, no sequence
    reg_wr(8'h10);
    mov(1, 16'h0100, 8'h3c);
    chk(ramSeen, 1);
    chk(cpuHold, 0);
    reg_wr(8'h38);
    for (int k = 0; k < 5; k++) begin
      d[k] = 8'($random(seed));
      if (k == 4)
        reg_wr(8'h18);
      mov(1, 16'h0240 + k, d[k]);
      if (k < 4)
        chk(cpuHold, 0);
    end
    chk(cpuHold, 1);
    chk(intDefer, 1);
    chk(ramSeen, 0);
    wait_idle();
    for (int k = 0; k < 5; k++) chk(u_flash.mem[12'h640 + k], d[k]);
    v = 8'($random(seed));
    mov(1, 16'h0240, v);
    wait_idle();
    chk(u_flash.mem[12'h640], d[0] & v);
    reg_wr(8'h58);
    mov(1, 16'h0241, v);
    wait_idle();
    chk(u_flash.mem[12'h640], 8'hff);
    chk(u_flash.mem[12'h641], v);
    chk(u_flash.mem[12'h642], 8'hff);
    slowDone = 1;
    reg_wr(8'h90);
    for (int s = 0; s < 2; s++) begin
      signatureSelect = s[0];
      mov(1, 16'h0080, v ^ 8'h0f);
      chk(cpuHold, 1);
      wait_idle();
      chk(u_flash.mem[{1'b1, s[0], 10'h080}], v ^ 8'h0f);
    end
    signatureSelect = 0;
    reg_wr(8'h18);
    mov(1, 16'h0250, v);
    repeat (8) tick();
    brownoutLow = 1;
    wait_idle();
    brownoutLow = 0;
    chk(sfrRdata[2], 1);
    reg_wr(8'h1c);
    chk(sfrRdata[2], 1);
    reg_wr(8'h1a);
    chk(sfrRdata & 8'hfe, 8'h18);
    report_and_stop();
  end
endmodule // tb_flash_write_and_map_control
bind flash_write_and_map_control nvm_ctrl_monitor u_mon (.clk, .rst,
  .sfrAddr, .sfrWrite, .sfrWdata, .sfrRdata, .movReq, .movWrite, .movIsCode,
  .signatureSelect, .movAck, .movSpace, .ramWriteEn, .cpuHold, .intDefer,
  .brownoutLow, .appFuseEn, .flashErase);
